// ---- hw/slfc_defines.svh ----
// Constants for the segment LCD frame control block
`ifndef SLFC_DEFINES_SVH
`define SLFC_DEFINES_SVH
`define SLFC_NUM_SEG 40
`define SLFC_NUM_COM 4
`define SLFC_MEM_W 160
`define SLFC_CONTRAST_W 8
`define SLFC_FRAME_DIV_RST 16'h0100
`define SLFC_DUTY_STATIC 2'h0
`define SLFC_DUTY_HALF 2'h1
`define SLFC_DUTY_THIRD 2'h2
`define SLFC_DUTY_QUARTER 2'h3
`endif

// ---- hw/slfc_pkg.sv ----
// Types for the segment LCD frame control block
package slfc_pkg;
  typedef enum logic [1:0] {
    SLFC_OFF = 2'b00,
    SLFC_RUN = 2'b01,
    SLFC_BLANK = 2'b10
  } slfc_state_t;

  // Controls latched at each frame start
  typedef struct packed {
    logic blank;
    logic low_power_wave_sel;
    logic [7:0] contrast;
  } slfc_frame_ctrl_t;

  // Sleep and clock context
  typedef struct packed {
    logic async_clk_sel;
    logic ext_clk_in_en;
    logic sys_clk_is_rc;
    logic sleep_idle;
    logic sleep_adc_nr;
    logic sleep_psave;
  } slfc_clk_ctx_t;
endpackage

// ---- hw/slfc_frame_control.sv ----
// Frame-level control of a segment LCD driver
//
// Function
// - Low-power waveform reaches zero DC across two frames of identical data.
// - Low-power waveform latches data and sets frame flag every second frame.
// - Synchronous clock keeps display running in Idle and Power-save.
// - Async clock with internal RC keeps Idle, ADC noise, Power-save running.
// - Async clock with external option enables oscillator pin input buffer.
// - Blank request takes effect only after current frame completes.
// - Blanked: all outputs at ground, display memory untouched.
// - Unused commons and masked segments return to port function.
// - Memory, blank, waveform, contrast captured just before each frame, or each frame pair in low-power mode.
// - On disable all LCD pins revert to port function.
// - Frame flag set at frame start; write one or vector clears it.
// - Duty select activates one to four commons.
// - Clearing enable stops the controller immediately.
// - Clock select: system clock when zero, async source when one.
`timescale 1ns/1ns
`include "slfc_defines.svh"

module slfc_frame_control #(
  parameter int NUM_SEG = `SLFC_NUM_SEG,
  parameter int MEM_W = `SLFC_MEM_W,
  parameter logic [15:0] FRAME_DIV = `SLFC_FRAME_DIV_RST
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic drive_on_i,
  input wire logic blank_req_i,
  input wire logic low_power_wave_sel_i,
  input wire logic [7:0] contrast_ctrl_reg_i,
  input wire logic [1:0] duty_sel_i,
  input wire logic [3:0] seg_pin_mask_i,
  input wire logic [MEM_W-1:0] display_mem_i,
  input wire logic flag_clr_i,
  input wire logic irq_ack_i,
  input wire logic async_tick_i,
  input wire slfc_pkg::slfc_clk_ctx_t clk_ctx_i,
  // Status and frame outputs
  output logic frame_start_flag_o,
  output logic frame_start_o,
  output logic display_run_o,
  output logic ext_clk_in_en_o,
  output logic [MEM_W-1:0] mem_latch_o,
  output slfc_pkg::slfc_frame_ctrl_t frame_ctrl_o,
  output logic [3:0] com_lcd_en_o,
  output logic [NUM_SEG-1:0] seg_lcd_en_o,
  output logic blanked_o,
  output logic pair_phase_o
);
  slfc_pkg::slfc_state_t state_q, state_d;
  logic [15:0] div_q;
  logic pair_q;
  logic flag_q;

  // Tick source: system clock or async domain pulse
  wire tick = clk_ctx_i.async_clk_sel ? async_tick_i : 1'b1;
  wire frame_end = tick && (div_q == FRAME_DIV - 16'h0001);
  // Latch only at the first frame of a pair in low-power mode
  wire pair_edge = !frame_ctrl_o.low_power_wave_sel || !pair_q;
  wire latch_now = frame_end && pair_edge && drive_on_i;
  wire [3:0] com_used = (duty_sel_i == `SLFC_DUTY_STATIC) ? 4'h1 :
                        (duty_sel_i == `SLFC_DUTY_HALF) ? 4'h3 :
                        (duty_sel_i == `SLFC_DUTY_THIRD) ? 4'h7 : 4'hf;
  logic [5:0] seg_cnt;
  always_comb begin
    case (seg_pin_mask_i)
      4'h0: seg_cnt = 6'd13;
      4'h1: seg_cnt = 6'd15;
      4'h2: seg_cnt = 6'd17;
      4'h3: seg_cnt = 6'd19;
      4'h4: seg_cnt = 6'd21;
      4'h5: seg_cnt = 6'd23;
      4'h6: seg_cnt = 6'd24;
      4'h7: seg_cnt = 6'd25;
      4'h8: seg_cnt = 6'd27;
      4'h9: seg_cnt = 6'd29;
      4'ha: seg_cnt = 6'd31;
      4'hb: seg_cnt = 6'd33;
      4'hc: seg_cnt = 6'd35;
      4'hd: seg_cnt = 6'd37;
      4'he: seg_cnt = 6'd39;
      default: seg_cnt = 6'd40;
    endcase
  end
  wire sleep_ok_sync = !clk_ctx_i.async_clk_sel &&
                       (clk_ctx_i.sleep_idle || clk_ctx_i.sleep_psave);
  wire sleep_ok_async = clk_ctx_i.async_clk_sel && clk_ctx_i.sys_clk_is_rc &&
                        (clk_ctx_i.sleep_idle || clk_ctx_i.sleep_adc_nr ||
                         clk_ctx_i.sleep_psave);
  wire any_sleep = clk_ctx_i.sleep_idle || clk_ctx_i.sleep_adc_nr ||
                   clk_ctx_i.sleep_psave;
  wire run_ok = drive_on_i && (!any_sleep || sleep_ok_sync || sleep_ok_async);

  always_comb begin
    state_d = state_q;
    case (state_q)
      slfc_pkg::SLFC_OFF: begin
        if (drive_on_i) state_d = slfc_pkg::SLFC_RUN;
      end
      slfc_pkg::SLFC_RUN: begin
        if (latch_now && blank_req_i) state_d = slfc_pkg::SLFC_BLANK;
      end
      slfc_pkg::SLFC_BLANK: begin
        if (latch_now && !blank_req_i) state_d = slfc_pkg::SLFC_RUN;
      end
      default: state_d = slfc_pkg::SLFC_OFF;
    endcase
    if (!drive_on_i) state_d = slfc_pkg::SLFC_OFF;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || !drive_on_i) begin
      div_q <= 16'h0000;
      pair_q <= 1'b0;
    end else if (frame_end) begin
      div_q <= 16'h0000;
      // A low-power latch opens a pair, so the next frame repeats its data
      pair_q <= latch_now && low_power_wave_sel_i;
    end else if (tick) begin
      div_q <= div_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= slfc_pkg::SLFC_OFF;
      mem_latch_o <= '0;
      frame_ctrl_o <= '0;
      frame_start_o <= 1'b0;
    end else begin
      state_q <= state_d;
      frame_start_o <= latch_now;
      if (latch_now) begin
        mem_latch_o <= display_mem_i;
        frame_ctrl_o <= {blank_req_i, low_power_wave_sel_i, contrast_ctrl_reg_i};
      end
    end
  end

  // Set wins over clear
  always_ff @(posedge clk_i) begin
    if (reset_i) flag_q <= 1'b0;
    else if (latch_now) flag_q <= 1'b1;
    else if (flag_clr_i || irq_ack_i) flag_q <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      frame_start_flag_o <= 1'b0;
      display_run_o <= 1'b0;
      ext_clk_in_en_o <= 1'b0;
      com_lcd_en_o <= 4'h0;
      blanked_o <= 1'b0;
      pair_phase_o <= 1'b0;
    end else begin
      frame_start_flag_o <= latch_now || (flag_q && !flag_clr_i && !irq_ack_i);
      display_run_o <= run_ok && state_d == slfc_pkg::SLFC_RUN;
      ext_clk_in_en_o <= clk_ctx_i.async_clk_sel && clk_ctx_i.ext_clk_in_en;
      com_lcd_en_o <= drive_on_i ? com_used : 4'h0;
      blanked_o <= state_d == slfc_pkg::SLFC_BLANK;
      pair_phase_o <= pair_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_SEG; g++) begin : g_seg
      always_ff @(posedge clk_i) begin
        if (reset_i) seg_lcd_en_o[g] <= 1'b0;
        else seg_lcd_en_o[g] <= drive_on_i && (g < seg_cnt);
      end
    end
  endgenerate

  // Frame ends skipped since the last latch; a fresh enable counts as a closed pair
  logic [1:0] gap_q;
  always_ff @(posedge clk_i) begin
    if (reset_i || !drive_on_i) gap_q <= 2'h1;
    else if (latch_now) gap_q <= 2'h0;
    else if (frame_end && gap_q != 2'h3) gap_q <= gap_q + 2'h1;
  end

  sequence s_latch;
    latch_now && blank_req_i;
  endsequence
  AST_BLANK_AT_FRAME: assert property (@(posedge clk_i) disable iff (reset_i)
    s_latch ##1 drive_on_i |-> blanked_o) else $error("blank not entered");
  AST_NO_EARLY_BLANK: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(blanked_o) |-> $past(latch_now)) else $error("blank mid frame");
  AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (reset_i)
    latch_now |=> flag_q) else $error("flag not set");
  AST_OFF_NOW: assert property (@(posedge clk_i) disable iff (reset_i)
    !drive_on_i |=> state_q == slfc_pkg::SLFC_OFF && com_lcd_en_o == 4'h0)
    else $error("not stopped");
  AST_LP_PAIR: assert property (@(posedge clk_i) disable iff (reset_i)
    latch_now && frame_ctrl_o.low_power_wave_sel |-> !pair_q) else $error("odd latch");
  AST_MEM_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    !$past(latch_now) |-> $stable(mem_latch_o)) else $error("memory changed");
  AST_EXT_CLK: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_ctx_i.async_clk_sel && clk_ctx_i.ext_clk_in_en |=> ext_clk_in_en_o)
    else $error("ext buffer off");
  AST_DUTY: assert property (@(posedge clk_i) disable iff (reset_i)
    drive_on_i && duty_sel_i == `SLFC_DUTY_HALF |=> com_lcd_en_o == 4'h3)
    else $error("duty commons");
  sequence s_lp_latch;
    latch_now && frame_ctrl_o.low_power_wave_sel;
  endsequence
  AST_LP_GAP: assert property (@(posedge clk_i) disable iff (reset_i)
    s_lp_latch |-> gap_q == 2'h1) else $error("pair not held");
  AST_FLAG_CLEAR: assert property (@(posedge clk_i) disable iff (reset_i)
    (flag_clr_i || irq_ack_i) && !latch_now |=> !frame_start_flag_o)
    else $error("flag not cleared");
endmodule

// ---- test/slfc_panel.sv ----
// Passive segment panel model that flags pins released while not discharged
`timescale 1ns/1ns
module slfc_panel (
  // Clock
  input wire logic clk_i,
  // Panel pins
  input wire logic [3:0] com_lcd_en_i,
  input wire logic blanked_i,
  // Status
  output logic dc_left_o
);
  logic [3:0] com_q = 4'h0;
  logic blank_q = 1'b0;
  initial dc_left_o = 1'b0;
  always @(posedge clk_i) begin
    com_q <= com_lcd_en_i;
    blank_q <= blanked_i;
    if (com_q != 4'h0 && com_lcd_en_i == 4'h0 && !blank_q) dc_left_o <= 1'b1;
  end
endmodule

// ---- test/segment_lcd_frame_control_test.sv ----
// Self-checking bench for the segment LCD frame control block
`timescale 1ns/1ns
module segment_lcd_frame_control_test;
  localparam int FD = 4;
  logic clk_i = 1'b0, reset_i = 1'b1, drive_on_i = 1'b0, blank_req_i = 1'b0, lpw = 1'b0;
  logic flag_clr_i = 1'b0, irq_ack_i = 1'b0, async_tick_i = 1'b0;
  logic [7:0] contrast = 8'h5a;
  logic [1:0] duty = 2'h3;
  logic [3:0] mask = 4'hf;
  logic [159:0] mem = {5{32'h0123abcd}};
  slfc_pkg::slfc_clk_ctx_t ctx = '0;
  logic fso, flag, run, extc, blk, dc, pp;
  logic [159:0] ml;
  slfc_pkg::slfc_frame_ctrl_t fc;
  logic [3:0] com;
  logic [39:0] seg;
  int bad_count = 0, num_checks = 0, c;
  int segn[4] = '{13, 23, 31, 40};
  always #4 clk_i = ~clk_i;
  slfc_frame_control #(.FRAME_DIV(16'h0004)) slfc_frame_control_i (.clk_i(clk_i),
    .reset_i(reset_i), .drive_on_i(drive_on_i), .blank_req_i(blank_req_i),
    .low_power_wave_sel_i(lpw), .contrast_ctrl_reg_i(contrast), .duty_sel_i(duty),
    .seg_pin_mask_i(mask), .display_mem_i(mem), .flag_clr_i(flag_clr_i),
    .irq_ack_i(irq_ack_i), .async_tick_i(async_tick_i), .clk_ctx_i(ctx),
    .frame_start_flag_o(flag), .frame_start_o(fso), .display_run_o(run),
    .ext_clk_in_en_o(extc), .mem_latch_o(ml), .frame_ctrl_o(fc), .com_lcd_en_o(com),
    .seg_lcd_en_o(seg), .blanked_o(blk), .pair_phase_o(pp));
  slfc_panel slfc_panel_i (.clk_i(clk_i), .com_lcd_en_i(com), .blanked_i(blk),
    .dc_left_o(dc));
  task chk(input logic [159:0] g, input logic [159:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Waits for the next frame start, counting cycles
  task wait_frame;
    for (c = 1; c < 64; c++) begin
      @(negedge clk_i);
      if (fso === 1'b1) break;
    end
    if (c == 64) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task pulse_clear(input logic ack);
    @(posedge clk_i);
    if (ack) irq_ack_i <= 1'b1;
    else flag_clr_i <= 1'b1;
    @(posedge clk_i);
    irq_ack_i <= 1'b0;
    flag_clr_i <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    @(negedge clk_i);
    chk(flag, 1'b0);
    @(posedge clk_i);
    drive_on_i <= 1'b1;
    wait_frame();
    chk(ml, mem);
    chk({flag, fc.contrast}, {1'b1, 8'h5a});
    @(posedge clk_i);
    mem <= ~mem;
    @(negedge clk_i);
    chk(ml, ~mem);
    wait_frame();
    chk(ml, mem);
    pulse_clear(1'b1);
    @(negedge clk_i);
    chk(flag, 1'b0);
    // Blank, switch off, reconfigure, switch on again
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      blank_req_i <= 1'b1;
      wait_frame();
      @(posedge clk_i);
      drive_on_i <= 1'b0;
      blank_req_i <= 1'b0;
      duty <= 2'(i);
      mask <= 4'(i * 5);
      @(posedge clk_i);
      drive_on_i <= 1'b1;
      wait_frame();
      wait_frame();
      chk(com, (4'h1 << (i + 1)) - 4'h1);
      chk(seg, {120'h0, ~(40'hffffffffff << segn[i])});
    end
    @(posedge clk_i);
    ctx <= 6'b000001;
    repeat (2) @(negedge clk_i);
    chk(run, 1'b1);
    @(posedge clk_i);
    ctx <= 6'b111010;
    async_tick_i <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk({run, extc}, 2'b11);
    @(posedge clk_i);
    ctx <= 6'b000000;
    async_tick_i <= 1'b0;
    lpw <= 1'b1;
    repeat (3) wait_frame();
    chk(c, 2 * FD);
    @(negedge clk_i);
    chk(pp, 1'b1);
    @(posedge clk_i);
    lpw <= 1'b0;
    repeat (2) wait_frame();
    chk(c, FD);
    @(posedge clk_i);
    blank_req_i <= 1'b1;
    pulse_clear(1'b0);
    @(negedge clk_i);
    chk({blk, flag}, 2'b00);
    wait_frame();
    chk({blk, fc.blank, flag}, 3'b111);
    chk(ml, mem);
    @(posedge clk_i);
    drive_on_i <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk({com, seg}, 44'h0);
    chk(dc, 1'b0);
    tally_and_finish();
  end
endmodule
